// ==== test/adc_pm_monitor.sv ====
// Port-level checker for power sequencing, pulse widths and lane pairing.
`timescale 1ns/100ps
module adc_pm_monitor (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic differential_mode_i,
	input wire logic serial_clock_p_i,
	input wire logic channel1_serial_out_p_o,
	input wire logic channel1_serial_out_n_o,
	input wire logic channel2_serial_out_p_o,
	input wire logic channel2_serial_out_n_o,
	input wire logic echoed_data_clock_p_o,
	input wire logic echoed_data_clock_n_o,
	input wire logic sample_mode_o,
	input wire logic convert_start_o,
	input wire adc_pm_pkg::pm_state_t power_state_o,
	input wire logic wake_from_sleep_o
);
	import adc_pm_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_left_sleep;
		$past(power_state_o) == PM_SLEEP ##0 power_state_o == PM_OPERATIONAL;
	endsequence
	property p_wake;
		wake_from_sleep_o |-> s_left_sleep ##1 !wake_from_sleep_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake pulse without leaving sleep");
	property p_conv;
		convert_start_o |-> !sample_mode_o ##1 !convert_start_o;
	endproperty
	a_conv: assert property (p_conv) else $error("convert start malformed");
	property p_nap;
		$changed(power_state_o) && power_state_o == PM_NAP |-> $past(power_state_o) == PM_OPERATIONAL;
	endproperty
	a_nap: assert property (p_nap) else $error("nap not entered from operational");
	property p_sleep;
		$changed(power_state_o) && power_state_o == PM_SLEEP |-> $past(power_state_o) == PM_NAP;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered from nap");
	property p_op_entry;
		$changed(power_state_o) && $past(power_state_o) == PM_SLEEP |-> wake_from_sleep_o;
	endproperty
	a_op_entry: assert property (p_op_entry) else $error("sleep exit without wake");
	property p_se_low;
		!differential_mode_i |-> !(channel1_serial_out_n_o | channel2_serial_out_n_o | echoed_data_clock_n_o);
	endproperty
	a_se_low: assert property (p_se_low) else $error("complement pin driven");
	property p_diff;
		differential_mode_i |-> channel1_serial_out_n_o == !channel1_serial_out_p_o
			&& channel2_serial_out_n_o == !channel2_serial_out_p_o
			&& echoed_data_clock_n_o == !echoed_data_clock_p_o;
	endproperty
	a_diff: assert property (p_diff) else $error("pair not complementary");
	// The echo can only rise once the synchroniser has seen the pin high.
	property p_echo;
		$rose(echoed_data_clock_p_o) |-> $past(serial_clock_p_i, 2);
	endproperty
	a_echo: assert property (p_echo) else $error("echo rose without clock");
endmodule
bind adc_power_mode_serial_out adc_pm_monitor u_mon (.*);

// ==== test/host_model.sv ====
// Host model: drives strobe and serial clock, gathers both lanes on the echo.
`timescale 1ns/100ps
module host_model (
	input wire logic clk_i,
	input wire logic differential_mode_i,
	input wire logic echo_i,
	input wire logic lane1_i,
	input wire logic lane2_i,
	output logic strobe_o,
	output logic sclk_p_o,
	output logic sclk_n_o,
	output logic [15:0] word1_o,
	output logic [15:0] word2_o
);
	logic echo_q;
	// The full recharge interval after a wake is far past the run budget, and
	// nothing in this model recharges, so the host waits only a token time.
	localparam int SETTLE_CYCLES = 100;
	assign sclk_n_o = differential_mode_i ? !sclk_p_o : 1'h0;
	initial begin
		strobe_o = 1'h0;
		sclk_p_o = 1'h0;
	end
	always @(posedge clk_i) begin
		echo_q <= echo_i;
		if (echo_i && !echo_q) begin
			word1_o <= {word1_o[14:0], lane1_i};
			word2_o <= {word2_o[14:0], lane2_i};
		end
	end
	task automatic strobe();
		@(posedge clk_i);
		#1 strobe_o = 1'h1;
		#80 strobe_o = 1'h0;
		#80;
	endtask
	task automatic settle();
		repeat (SETTLE_CYCLES) @(posedge clk_i);
		#1;
	endtask
	task automatic clocks(input int n);
		@(posedge clk_i);
		#1;
		repeat (n) begin
			sclk_p_o = 1'h1;
			#40 sclk_p_o = 1'h0;
			#40;
		end
	endtask
endmodule

// ==== test/test_adc_power_mode_serial_out.sv ====
// Self-checking bench for the power sequencer and serial result output.
`timescale 1ns/100ps
module test_adc_power_mode_serial_out;
	import adc_pm_pkg::*;
	logic clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic diff = 1'h0;
	logic [15:0] r1 = 16'hA5C3;
	logic [15:0] r2 = 16'h3C5A;
	logic stb, skp, skn, c1p, c1n, c2p, c2n, ep, en, smp, cvs, wk;
	logic [15:0] w1, w2;
	pm_state_t st;
	int failures = 0, n_compared = 0, wakes = 0, convs = 0, samples = 0;
	always #5 clk_i = !clk_i;
	always @(posedge clk_i) begin
		wakes += wk;
		convs += cvs;
		samples += smp;
	end
	host_model host (.clk_i(clk_i), .differential_mode_i(diff), .echo_i(ep), .lane1_i(c1p),
		.lane2_i(c2p), .strobe_o(stb), .sclk_p_o(skp), .sclk_n_o(skn), .word1_o(w1), .word2_o(w2));
	adc_power_mode_serial_out dut (.clk_i(clk_i), .rstn_i(rstn_i), .conversion_strobe_i(stb),
		.serial_clock_p_i(skp), .serial_clock_n_i(skn), .differential_mode_i(diff),
		.channel1_result_i(r1), .channel2_result_i(r2), .channel1_serial_out_p_o(c1p),
		.channel1_serial_out_n_o(c1n), .channel2_serial_out_p_o(c2p),
		.channel2_serial_out_n_o(c2n), .echoed_data_clock_p_o(ep), .echoed_data_clock_n_o(en),
		.sample_mode_o(smp), .convert_start_o(cvs), .power_state_o(st), .wake_from_sleep_o(wk));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// The select is static, so it only changes while reset is held.
	task automatic rst(input logic d);
		rstn_i = 1'h0;
		diff = d;
		repeat (8) @(posedge clk_i);
		#1 rstn_i = 1'h1;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic t_read(input logic d);
		logic [15:0] e1, e2;
		rst(d);
		e1 = r1;
		e2 = r2;
		samples = 0;
		convs = 0;
		host.strobe();
		r1 = ~r1;
		r2 = ~r2;
		chk("sampled", 16'h0001, 16'(samples != 0));
		chk("converts", 16'h0001, 16'(convs));
		host.clocks(17);
		chk("lane1", e1, w1);
		chk("lane2", e2, w2);
	endtask
	task automatic t_cycle(input logic d);
		pm_state_t exp [7] = '{PM_OPERATIONAL, PM_NAP, PM_NAP, PM_SLEEP, PM_OPERATIONAL,
			PM_OPERATIONAL, PM_NAP};
		rst(d);
		wakes = 0;
		foreach (exp[i]) begin
			host.strobe();
			chk("cycle state", 16'(exp[i]), 16'(st));
		end
		chk("cycle wakes", 16'h0001, 16'(wakes));
	endtask
	task automatic t_sck(input logic d);
		rst(d);
		host.strobe();
		host.clocks(1);
		host.strobe();
		chk("cleared", 16'(PM_OPERATIONAL), 16'(st));
		host.strobe();
		chk("nap", 16'(PM_NAP), 16'(st));
		host.clocks(1);
		chk("nap exit", 16'(PM_OPERATIONAL), 16'(st));
		repeat (4) host.strobe();
		chk("sleep", 16'(PM_SLEEP), 16'(st));
		wakes = 0;
		host.clocks(1);
		chk("clock wake", d ? 16'(PM_SLEEP) : 16'(PM_OPERATIONAL), 16'(st));
		chk("wake pulse", 16'(!d), 16'(wakes));
		host.settle();
	endtask
	task automatic conclude();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		for (int d = 0; d < 2; d++) begin
			t_read(d[0]);
			t_cycle(d[0]);
			t_sck(d[0]);
		end
		conclude();
	end
endmodule

// ==== verilog/adc_pm_pkg.sv ====
// Shared constants and types for the power sequencer and serial result output.
package adc_pm_pkg;
	localparam int RESULT_W = 16;
	localparam logic [4:0] BIT_CNT_RST = 5'h0_0;
	localparam logic [4:0] BIT_CNT_LAST = 5'h0_F;
	localparam logic [2:0] STROBE_CNT_RST = 3'h0;
	localparam logic [2:0] NAP_STROBES = 3'h2;
	localparam logic [2:0] SLEEP_STROBES = 3'h4;
	localparam logic [2:0] WAKE_STROBES = 3'h5;
	localparam logic [2:0] SYNC_RST = 3'h0;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	// Sync stage count for pin inputs.
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {
		PM_OPERATIONAL,
		PM_NAP,
		PM_SLEEP
	} pm_state_t;
endpackage

// ==== verilog/adc_power_mode_serial_out.sv ====
// Power mode sequencer and dual-lane serial result output of the converter.
//
// What this block does
// - Second strobe rising edge while serial clock idle enters nap.
// - Nap persists until one serial clock rising edge or further strobes.
// - Two more idle strobes while in nap enter sleep.
// - Single-ended mode: one serial clock rising edge wakes from sleep.
// - Fifth strobe of the sequence leaves sleep for operational mode.
// - Serial clock pulses between strobes stop counting toward nap or sleep.
// - Without serial clock pulses, strobes cycle operational, nap, sleep forever.
// - A static select input chooses single-ended or differential interface.
// - Each serial clock falling edge in operational mode shifts next result bit out, MSB first.
// - Echoed data clock drives skew-matched with the data lanes.
// - Single-ended mode drives positive pins only; complementary pins held low.
// - Differential mode drives data and echoed clock as complementary pairs.
// - Strobe rising edge in operational mode starts sampling; falling edge holds and starts conversion.
`timescale 1ns/100ps
module adc_power_mode_serial_out (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic conversion_strobe_i,
	input wire logic serial_clock_p_i,
	input wire logic serial_clock_n_i,
	input wire logic differential_mode_i,
	input wire logic [adc_pm_pkg::RESULT_W-1:0] channel1_result_i,
	input wire logic [adc_pm_pkg::RESULT_W-1:0] channel2_result_i,
	output logic channel1_serial_out_p_o,
	output logic channel1_serial_out_n_o,
	output logic channel2_serial_out_p_o,
	output logic channel2_serial_out_n_o,
	output logic echoed_data_clock_p_o,
	output logic echoed_data_clock_n_o,
	output logic sample_mode_o,
	output logic convert_start_o,
	output adc_pm_pkg::pm_state_t power_state_o,
	output logic wake_from_sleep_o
);
	import adc_pm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.
	// Stage one feeds only stage two; edges are judged once stages two and three agree.

	logic [SYNC_STAGES-1:0] strobe_sync_ff;
	logic [SYNC_STAGES-1:0] sclk_sync_ff;
	logic [SYNC_STAGES-1:0] nxt_strobe_sync;
	logic [SYNC_STAGES-1:0] nxt_sclk_sync;
	logic strobe_lvl_ff;
	logic sclk_lvl_ff;
	logic nxt_strobe_lvl;
	logic nxt_sclk_lvl;
	logic sclk_pin;
	logic strobe_rise;
	logic strobe_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic [SYNC_STAGES-1:0] prime_ff;
	logic [SYNC_STAGES-1:0] nxt_prime;
	logic priming;

	// Returns true when the two settled stages agree on a level differing from the held one.
	function automatic logic settled_change(input logic [SYNC_STAGES-1:0] s, input logic held);
		settled_change = (s[1] == s[2]) && (s[2] != held);
	endfunction

	always_comb begin
		// Serial clock pin choice follows the mode select.
		sclk_pin = differential_mode_i ? (serial_clock_p_i & ~serial_clock_n_i) : serial_clock_p_i;
		nxt_strobe_sync = {strobe_sync_ff[1:0], conversion_strobe_i};
		nxt_sclk_sync = {sclk_sync_ff[1:0], sclk_pin};
		nxt_strobe_lvl = strobe_lvl_ff;
		nxt_sclk_lvl = sclk_lvl_ff;
		strobe_rise = 1'b0;
		strobe_fall = 1'b0;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		nxt_prime = {prime_ff[SYNC_STAGES-2:0], 1'b1};
		priming = ~prime_ff[SYNC_STAGES-1];
		if (priming) begin
			// The held levels restart low, but the serial clock may idle high. Taking the
			// pin level quietly for the first cycles after reset stops a false edge from
			// reaching the sequencer and shifter. An edge inside that short window is lost.
			nxt_strobe_lvl = strobe_sync_ff[1];
			nxt_sclk_lvl = sclk_sync_ff[1];
		end else begin
			if (settled_change(strobe_sync_ff, strobe_lvl_ff)) begin
				nxt_strobe_lvl = strobe_sync_ff[2];
				strobe_rise = strobe_sync_ff[2];
				strobe_fall = ~strobe_sync_ff[2];
			end
			if (settled_change(sclk_sync_ff, sclk_lvl_ff)) begin
				nxt_sclk_lvl = sclk_sync_ff[2];
				sclk_rise = sclk_sync_ff[2];
				sclk_fall = ~sclk_sync_ff[2];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strobe_sync_ff <= SYNC_RST;
			sclk_sync_ff <= SYNC_RST;
			strobe_lvl_ff <= 1'b0;
			sclk_lvl_ff <= 1'b0;
			prime_ff <= SYNC_RST;
		end else begin
			strobe_sync_ff <= nxt_strobe_sync;
			sclk_sync_ff <= nxt_sclk_sync;
			strobe_lvl_ff <= nxt_strobe_lvl;
			sclk_lvl_ff <= nxt_sclk_lvl;
			prime_ff <= nxt_prime;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power mode sequencer.
	// A serial clock rise outranks a strobe rise in the same cycle, so the count is cleared.

	pm_state_t state_ff;
	pm_state_t nxt_state;
	logic [2:0] strobe_cnt_ff;
	logic [2:0] nxt_strobe_cnt;
	logic wake_ff;
	logic nxt_wake;

	always_comb begin
		nxt_state = state_ff;
		nxt_strobe_cnt = strobe_cnt_ff;
		nxt_wake = 1'b0;
		if (sclk_rise) begin
			nxt_strobe_cnt = STROBE_CNT_RST;
			case (state_ff)
				PM_NAP: nxt_state = PM_OPERATIONAL;
				PM_SLEEP: begin
					// Differential sleep does not wake on the clock, which still clears the count; only the fifth strobe wakes it.
					// single-ended wake
					if (!differential_mode_i) begin
						nxt_state = PM_OPERATIONAL;
						nxt_wake = 1'b1;
					end
				end
				default: nxt_state = state_ff;
			endcase
		end else if (strobe_rise) begin
			nxt_strobe_cnt = strobe_cnt_ff + 3'h1;
			case (state_ff)
				PM_OPERATIONAL: begin
					if (nxt_strobe_cnt == NAP_STROBES) begin
						nxt_state = PM_NAP;
					end
				end
				PM_NAP: begin
					if (nxt_strobe_cnt == SLEEP_STROBES) begin
						nxt_state = PM_SLEEP;
					end
				end
				PM_SLEEP: begin
					if (nxt_strobe_cnt >= WAKE_STROBES) begin
						nxt_state = PM_OPERATIONAL;
						nxt_wake = 1'b1;
						nxt_strobe_cnt = STROBE_CNT_RST;
					end
				end
				default: nxt_state = PM_OPERATIONAL;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff <= PM_OPERATIONAL;
			strobe_cnt_ff <= STROBE_CNT_RST;
			wake_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			strobe_cnt_ff <= nxt_strobe_cnt;
			wake_ff <= nxt_wake;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample control and serial shifter.
	// The result words are latched at the strobe falling edge so the shift sees a stable word.

	logic sample_ff;
	logic nxt_sample;
	logic conv_ff;
	logic nxt_conv;
	logic [RESULT_W-1:0] sh1_ff;
	logic [RESULT_W-1:0] sh2_ff;
	logic [RESULT_W-1:0] nxt_sh1;
	logic [RESULT_W-1:0] nxt_sh2;
	logic [4:0] bit_cnt_ff;
	logic [4:0] nxt_bit_cnt;
	logic d1_ff;
	logic d2_ff;
	logic eclk_ff;
	logic nxt_d1;
	logic nxt_d2;
	logic nxt_eclk;

	// True while the sequencer is at full power; sampling and shifting need it.
	function automatic logic is_operational(input pm_state_t s);
		is_operational = (s == PM_OPERATIONAL);
	endfunction

	always_comb begin
		nxt_sample = sample_ff;
		nxt_conv = 1'b0;
		nxt_sh1 = sh1_ff;
		nxt_sh2 = sh2_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_d1 = d1_ff;
		nxt_d2 = d2_ff;
		// Echo takes the new level on the same edge that launches the data bit.
		// echo tracks clock
		nxt_eclk = nxt_sclk_lvl;
		// Sampling and shifting pause outside full power; a word left mid-shift resumes later.
		// rise samples
		if (strobe_rise && is_operational(state_ff)) begin
			nxt_sample = 1'b1;
		end
		if (strobe_fall && sample_ff) begin
			nxt_sample = 1'b0;
			nxt_conv = 1'b1;
			nxt_sh1 = channel1_result_i;
			nxt_sh2 = channel2_result_i;
			nxt_bit_cnt = BIT_CNT_RST;
		end else if (sclk_fall && is_operational(state_ff)) begin
			if (bit_cnt_ff <= BIT_CNT_LAST) begin
				nxt_d1 = sh1_ff[RESULT_W-1];
				nxt_d2 = sh2_ff[RESULT_W-1];
				nxt_sh1 = {sh1_ff[RESULT_W-2:0], 1'b0};
				nxt_sh2 = {sh2_ff[RESULT_W-2:0], 1'b0};
				nxt_bit_cnt = bit_cnt_ff + 5'h0_1;
			end else begin
				// Once all sixteen bits are out the lanes rest low until the next word.
				nxt_d1 = 1'b0;
				nxt_d2 = 1'b0;
			end
		end
		if (!is_operational(state_ff)) begin
			nxt_sample = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sample_ff <= 1'b0;
			conv_ff <= 1'b0;
			sh1_ff <= RESULT_RST;
			sh2_ff <= RESULT_RST;
			bit_cnt_ff <= BIT_CNT_RST;
			d1_ff <= 1'b0;
			d2_ff <= 1'b0;
			eclk_ff <= 1'b0;
		end else begin
			sample_ff <= nxt_sample;
			conv_ff <= nxt_conv;
			sh1_ff <= nxt_sh1;
			sh2_ff <= nxt_sh2;
			bit_cnt_ff <= nxt_bit_cnt;
			d1_ff <= nxt_d1;
			d2_ff <= nxt_d2;
			eclk_ff <= nxt_eclk;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output pins.
	// Data and echo come from flops on the same edge, which keeps their skew matched.

	// Complement pins sit low in single-ended mode, as a pulled-down unused pin would.
	// mode select steers pins
	assign channel1_serial_out_p_o = d1_ff;
	assign channel2_serial_out_p_o = d2_ff;
	assign echoed_data_clock_p_o = eclk_ff;
	assign channel1_serial_out_n_o = differential_mode_i & ~d1_ff;
	assign channel2_serial_out_n_o = differential_mode_i & ~d2_ff;
	assign echoed_data_clock_n_o = differential_mode_i & ~eclk_ff;
	assign sample_mode_o = sample_ff;
	assign convert_start_o = conv_ff;
	assign power_state_o = state_ff;
	assign wake_from_sleep_o = wake_ff;
endmodule
